// ### design/wddc_core.v
`timescale 1ns/1ps
`include "wddc_defines.vh"

module wddc_core #(
    parameter FIFO_DEPTH = `WDDC_FIFO_DEPTH
) (
    input wire sys_clk, // 200 MHz clock
    input wire rst, // Sync reset, high
    input wire [7:0] paddr, // APB address
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error
    input wire [11:0] adcDataA, // Sample, path 0
    input wire [11:0] adcDataB, // Sample, path 1
    input wire adcValid, // Sample strobe
    output reg adcReady, // Samples taken
    output wire outValid, // I/Q present
    input wire outReady, // Drain accepts
    output wire outChan, // Path of word
    output wire [15:0] outI, // In-phase
    output wire [15:0] outQ // Quadrature
);
    localparam LW = $clog2(FIFO_DEPTH) + 1;
    localparam integer LIMIT_I = FIFO_DEPTH - `WDDC_FIFO_HEADROOM;
    localparam [LW-1:0] LIMIT = LIMIT_I[LW-1:0];

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Shift of the tap index; N is 32 >> shift
    function [1:0] decShift;
        input two;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: decShift = two ? 2'h3 : 2'h2;
                2'h1: decShift = two ? 2'h2 : 2'h1;
                default: decShift = two ? 2'h1 : 2'h0;
            endcase
        end
    endfunction

    // Sixteen-point cosine, Q15
    function [15:0] cosLut;
        input [3:0] k;
        begin
            case (k)
                4'h0: cosLut = 16'h7FFF;
                4'h1: cosLut = 16'h7642;
                4'h2: cosLut = 16'h5A82;
                4'h3: cosLut = 16'h30FC;
                4'h4: cosLut = 16'h0000;
                4'h5: cosLut = 16'hCF04;
                4'h6: cosLut = 16'hA57E;
                4'h7: cosLut = 16'h89BE;
                4'h8: cosLut = 16'h8001;
                4'h9: cosLut = 16'h89BE;
                4'hA: cosLut = 16'hA57E;
                4'hB: cosLut = 16'hCF04;
                4'hC: cosLut = 16'h0000;
                4'hD: cosLut = 16'h30FC;
                4'hE: cosLut = 16'h5A82;
                default: cosLut = 16'h7642;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [5:0] ctrl_q;
    reg [31:0] tune0_q;
    reg [31:0] tune1_q;
    reg [31:0] phOfs0_q;
    reg [31:0] phOfs1_q;
    reg [5:0] coefAddr_q;
    reg [15:0] coefMem [0:2*`WDDC_TAPS-1];
    reg fillDone_q;
    reg overrun_q;
    reg restart_q;
    reg [31:0] rdMux;

    wire [LW-1:0] level;
    wire enable = ctrl_q[`WDDC_CTRL_EN];
    wire two = ctrl_q[`WDDC_CTRL_TWO];
    wire [1:0] decSel = ctrl_q[`WDDC_CTRL_DEC_LO +: 2];
    wire apbAcc = psel && penable;
    wire wrCommit = apbAcc && pready && pwrite;
    wire isCtrl = paddr == `WDDC_OFS_CTRL;
    wire isCoef = paddr == `WDDC_OFS_COEF_DATA;
    wire isStat = paddr == `WDDC_OFS_STATUS;
    wire badDec = pwdata[`WDDC_CTRL_DEC_LO +: 2] == `WDDC_DEC_BAD;
    wire mapped = paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0;
    wire apbErr = !mapped || (pwrite && isCtrl && badDec);
    wire take = adcValid && adcReady;
    wire dump0;
    wire dump1;
    wire [31:0] res0;
    wire [31:0] res1;

    always @* begin
        rdMux = `WDDC_WORD_RST;
        case (paddr)
            `WDDC_OFS_CTRL: rdMux[5:0] = ctrl_q;
            `WDDC_OFS_TUNE0: rdMux = tune0_q;
            `WDDC_OFS_TUNE1: rdMux = tune1_q;
            `WDDC_OFS_PHASE0: rdMux = phOfs0_q;
            `WDDC_OFS_PHASE1: rdMux = phOfs1_q;
            `WDDC_OFS_COEF_ADDR: rdMux[5:0] = coefAddr_q;
            `WDDC_OFS_COEF_DATA: rdMux[15:0] = coefMem[coefAddr_q];
            `WDDC_OFS_STATUS: begin
                rdMux[`WDDC_ST_FILL] = fillDone_q;
                rdMux[`WDDC_ST_OVR] = overrun_q;
                rdMux[`WDDC_ST_LVL_LO +: LW] = level;
            end
            default: rdMux = `WDDC_WORD_RST;
        endcase
    end

    // ----------------------------------------
    // APB slave: one wait state, commit on the ready edge
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `WDDC_WORD_RST;
        end else begin
            pready <= apbAcc && !pready;
            pslverr <= apbAcc && !pready && apbErr;
            if (apbAcc && !pready) begin
                prdata <= pwrite ? `WDDC_WORD_RST : rdMux;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (wrCommit && isCoef && !apbErr) begin
            coefMem[coefAddr_q] <= pwdata[15:0];
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= `WDDC_CTRL_RST;
            tune0_q <= `WDDC_WORD_RST;
            tune1_q <= `WDDC_WORD_RST;
            phOfs0_q <= `WDDC_WORD_RST;
            phOfs1_q <= `WDDC_WORD_RST;
            coefAddr_q <= 6'h00;
            restart_q <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            restart_q <= wrCommit && isCtrl && !apbErr;
            if (wrCommit && !apbErr) begin
                case (paddr)
                    `WDDC_OFS_CTRL: ctrl_q <= pwdata[5:0];
                    `WDDC_OFS_TUNE0: tune0_q <= pwdata;
                    `WDDC_OFS_TUNE1: tune1_q <= pwdata;
                    `WDDC_OFS_PHASE0: phOfs0_q <= pwdata;
                    `WDDC_OFS_PHASE1: phOfs1_q <= pwdata;
                    `WDDC_OFS_COEF_ADDR: coefAddr_q <= pwdata[5:0];
                    `WDDC_OFS_COEF_DATA: coefAddr_q <= coefAddr_q + 1'b1;
                    default: coefAddr_q <= coefAddr_q;
                endcase
            end
            // A new overrun wins over a write-one clear
            if (enable && adcValid && !adcReady) begin
                overrun_q <= 1'b1;
            end else if (wrCommit && isStat && pwdata[`WDDC_ST_OVR]) begin
                overrun_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Sample window and shared first stage
    // ----------------------------------------
    reg [4:0] sampCnt_q;
    reg s1Valid_q;
    reg s1First_q;
    reg s1Last_q;
    reg [4:0] s1Tap_q;

    wire [1:0] shift = decShift(two, decSel);
    wire [5:0] decN = 6'h20 >> shift;
    wire lastSamp = {1'b0, sampCnt_q} == decN - 6'h01;
    wire [4:0] tapIdx = sampCnt_q << shift;

    always @(posedge sys_clk) begin
        if (rst || restart_q) begin
            sampCnt_q <= 5'h00;
            s1Valid_q <= 1'b0;
            s1First_q <= 1'b0;
            s1Last_q <= 1'b0;
            s1Tap_q <= 5'h00;
            // Room is kept for the words still in flight
            adcReady <= 1'b0;
        end else begin
            adcReady <= enable && level < LIMIT;
            s1Valid_q <= take;
            if (take) begin
                sampCnt_q <= lastSamp ? 5'h00 : sampCnt_q + 5'h01;
                s1First_q <= sampCnt_q == 5'h00;
                s1Last_q <= lastSamp;
                s1Tap_q <= tapIdx;
            end
        end
    end

    // ----------------------------------------
    // Two downconversion paths
    // ----------------------------------------
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : gPath
            reg [31:0] phase_q;
            reg signed [11:0] x_q;
            reg signed [15:0] cos_q;
            reg signed [15:0] sin_q;
            reg signed [39:0] accI_q;
            reg signed [39:0] accQ_q;
            reg [31:0] res_q;
            reg dump_q;

            wire on = (p == 0) || two;
            wire [31:0] tuneW = (p == 0) ? tune0_q : tune1_q;
            wire [31:0] ofsW = (p == 0) ? phOfs0_q : phOfs1_q;
            wire [31:0] phSum = phase_q + ofsW;
            wire user = ctrl_q[`WDDC_CTRL_UC0 + p];
            wire [15:0] coefRaw = coefMem[p * `WDDC_TAPS + s1Tap_q];
            // Default is flat; its rejection is that of an N-tap window
            wire signed [15:0] coef = user ? coefRaw : `WDDC_COEF_DEF;
            // Multiply by exp(-j phase): I = x cos, Q = -x sin
            wire signed [27:0] mixI = x_q * cos_q;
            wire signed [27:0] mixQ = -(x_q * sin_q);
            wire signed [31:0] prodI = $signed(mixI[27:12]) * coef;
            wire signed [31:0] prodQ = $signed(mixQ[27:12]) * coef;
            wire signed [39:0] baseI = s1First_q ? 40'sh00_0000_0000 : accI_q;
            wire signed [39:0] baseQ = s1First_q ? 40'sh00_0000_0000 : accQ_q;
            wire signed [39:0] nextI = baseI + prodI;
            wire signed [39:0] nextQ = baseQ + prodQ;

            always @(posedge sys_clk) begin
                if (rst || restart_q) begin
                    phase_q <= `WDDC_WORD_RST;
                    x_q <= 12'h000;
                    cos_q <= 16'h0000;
                    sin_q <= 16'h0000;
                    accI_q <= 40'sh00_0000_0000;
                    accQ_q <= 40'sh00_0000_0000;
                    res_q <= `WDDC_WORD_RST;
                    dump_q <= 1'b0;
                end else begin
                    dump_q <= 1'b0;
                    if (take && on) begin
                        phase_q <= phase_q + tuneW;
                        x_q <= (p == 0) ? adcDataA : adcDataB;
                        cos_q <= cosLut(phSum[31:28]);
                        sin_q <= cosLut(phSum[31:28] - 4'h4);
                    end
                    if (s1Valid_q && on) begin
                        accI_q <= nextI;
                        accQ_q <= nextQ;
                        if (s1Last_q) begin
                            res_q <= {nextI[35:20], nextQ[35:20]};
                            dump_q <= 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate

    assign dump0 = gPath[0].dump_q;
    assign dump1 = gPath[1].dump_q;
    assign res0 = gPath[0].res_q;
    assign res1 = gPath[1].res_q;

    // ----------------------------------------
    // Output merge: path 1 waits one cycle behind path 0
    // ----------------------------------------
    reg pend1_q;
    reg [31:0] hold1_q;
    wire fifoInReady;
    wire fifoWr = dump0 || pend1_q;
    wire [32:0] fifoIn = dump0 ? {1'b0, res0} : {1'b1, hold1_q};
    wire [32:0] fifoOut;

    always @(posedge sys_clk) begin
        if (rst || restart_q) begin
            pend1_q <= 1'b0;
            hold1_q <= `WDDC_WORD_RST;
            fillDone_q <= 1'b0;
        end else begin
            if (dump1) begin
                pend1_q <= 1'b1;
                hold1_q <= res1;
            end else if (!dump0 && fifoInReady) begin
                pend1_q <= 1'b0;
            end
            if (dump0) begin
                fillDone_q <= 1'b1;
            end
        end
    end

    wddc_fifo #(
        .WIDTH(33),
        .DEPTH(FIFO_DEPTH)
    ) uFifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .inValid(fifoWr),
        .inReady(fifoInReady),
        .inData(fifoIn),
        .outValid(outValid),
        .outReady(outReady),
        .outData(fifoOut),
        .level(level)
    );

    assign outChan = fifoOut[32];
    assign outI = fifoOut[31:16];
    assign outQ = fifoOut[15:0];
endmodule // wddc_core

// ### design/wddc_defines.vh
`ifndef WDDC_DEFINES_VH
`define WDDC_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define WDDC_OFS_CTRL 8'h00
`define WDDC_OFS_TUNE0 8'h04
`define WDDC_OFS_TUNE1 8'h08
`define WDDC_OFS_PHASE0 8'h0C
`define WDDC_OFS_PHASE1 8'h10
`define WDDC_OFS_COEF_ADDR 8'h14
`define WDDC_OFS_COEF_DATA 8'h18
`define WDDC_OFS_STATUS 8'h1C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WDDC_CTRL_EN 0
`define WDDC_CTRL_TWO 1
`define WDDC_CTRL_DEC_LO 2
`define WDDC_CTRL_UC0 4
`define WDDC_CTRL_UC1 5
`define WDDC_ST_FILL 0
`define WDDC_ST_OVR 1
`define WDDC_ST_LVL_LO 8

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define WDDC_CTRL_RST 6'h00
`define WDDC_WORD_RST 32'h0000_0000
`define WDDC_DEC_BAD 2'h3
`define WDDC_COEF_DEF 16'h0400
`define WDDC_TAPS 32
`define WDDC_FIFO_DEPTH 32
`define WDDC_FIFO_HEADROOM 4

`endif

// ### design/wddc_fifo.v
`timescale 1ns/1ps

module wddc_fifo #(
    parameter WIDTH = 33,
    parameter DEPTH = 32
) (
    input wire sys_clk, // Clock
    input wire rst, // Sync reset
    input wire inValid, // Write request
    output wire inReady, // Room for a word
    input wire [WIDTH-1:0] inData, // Write data
    output reg outValid, // Read word present
    input wire outReady, // Drain accepts
    output reg [WIDTH-1:0] outData, // Read word
    output wire [$clog2(DEPTH):0] level // Words in memory
);
    // DEPTH must be a power of two: pointers wrap naturally
    localparam AW = $clog2(DEPTH);
    localparam [AW:0] FULL = DEPTH[AW:0];

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;

    wire push = inValid && inReady;
    wire pop = (cnt_q != {(AW+1){1'b0}}) && (!outValid || outReady);

    assign inReady = cnt_q != FULL;
    assign level = cnt_q;

    always @(posedge sys_clk) begin
        if (push) begin
            mem[wp_q] <= inData;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            outValid <= 1'b0;
            outData <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
                outData <= mem[rp_q];
                outValid <= 1'b1;
            end else if (outReady) begin
                outValid <= 1'b0;
            end
            case ({push, pop})
                2'b10: cnt_q <= cnt_q + 1'b1;
                2'b01: cnt_q <= cnt_q - 1'b1;
                default: cnt_q <= cnt_q;
            endcase
        end
    end
endmodule // wddc_fifo

// ### tb/wddc_core_asserts.sv
`timescale 1ns/1ps
module wddc_core_asserts (
    input wire sys_clk, // Clock
    input wire rst, // Sync reset
    input wire [7:0] paddr, // APB address
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pready, // APB ready
    input wire pslverr, // APB error
    input wire adcValid, // Sample offered
    input wire adcReady, // Sample taken
    input wire outValid, // Word present
    input wire outReady, // Word taken
    input wire outChan, // Path of word
    input wire [15:0] outI, // In-phase
    input wire [15:0] outQ // Quadrature
);
    logic [19:0] sampCnt_q;
    logic [19:0] wordCnt_q;

    always @(posedge sys_clk) begin
        if (rst) begin
            sampCnt_q <= 20'h0_0000;
            wordCnt_q <= 20'h0_0000;
        end else begin
            sampCnt_q <= sampCnt_q + 20'(adcValid && adcReady);
            wordCnt_q <= wordCnt_q + 20'(outValid && outReady);
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence sAccess;
        psel && penable && !pready;
    endsequence
    sequence sWaitWord;
        outValid && !outReady;
    endsequence
    sequence sSameWord;
        outValid && $stable(outI) && $stable(outQ) && $stable(outChan);
    endsequence

    AST_RDY_AFTER_ACC: assert property (sAccess |=> pready)
        else $error("No ready one cycle after access");
    AST_RDY_CAUSE: assert property (pready |-> $past(psel && penable))
        else $error("Ready without an access");
    AST_RDY_PULSE: assert property (pready |=> !pready)
        else $error("Ready held two cycles");
    AST_ERR_WITH_RDY: assert property (pslverr |-> pready)
        else $error("Error outside ready cycle");
    AST_ERR_UNMAPPED: assert property (sAccess ##0
        (paddr >= 8'h20 || paddr[1:0] != 2'b00) |=> pslverr)
        else $error("Unmapped access not refused");
    AST_OUT_HOLD: assert property (sWaitWord |=> sSameWord)
        else $error("Output word changed while stalled");
    AST_NO_OUT_RESET: assert property ($fell(rst) |-> !outValid [*8])
        else $error("Output valid right after reset");
    AST_OUT_AFTER_SAMP: assert property (outValid |-> sampCnt_q >= 20'd4)
        else $error("Output before a full window");
    AST_WORD_RATE: assert property (wordCnt_q <= (sampCnt_q >> 1))
        else $error("More words than windows allow");
endmodule // wddc_core_asserts

bind wddc_core wddc_core_asserts wddc_core_asserts_i (.*);

// ### tb/wddc_adc_model.sv
`timescale 1ns/1ps
module wddc_adc_model (
    input wire logic sys_clk, // Clock
    input wire logic rst, // Sync reset
    input wire logic [15:0] total, // Samples per run
    input wire logic [11:0] amp, // Sample value
    input wire logic hold, // Stall drain
    output logic done, // Run complete
    output logic [11:0] adcDataA, // Path 0 sample
    output logic [11:0] adcDataB, // Path 1 sample
    output logic adcValid, // Sample offered
    input wire logic adcReady, // Sample taken
    input wire logic outValid, // Word offered
    output logic outReady // Word taken
);
    logic [15:0] sentCnt_q;
    logic [3:0] lfsr_q;

    // Lowering the total ends the offer at once, with no stray sample
    assign done = sentCnt_q >= total;
    // Offered every cycle: the core must keep up at full rate
    assign adcValid = !rst && !done;
    // Idle lines show the inverse so a stale sample never passes for data
    assign adcDataA = adcValid ? amp : ~amp;
    assign adcDataB = adcValid ? -amp : amp;
    assign outReady = !hold && (lfsr_q[0] || !outValid);

    always @(posedge sys_clk) begin
        if (rst || total == 16'h0000) begin
            sentCnt_q <= 16'h0000;
        end else if (adcValid && adcReady) begin
            sentCnt_q <= sentCnt_q + 16'h0001;
        end
        if (rst) begin
            lfsr_q <= 4'h1;
        end else begin
            lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
        end
    end
endmodule // wddc_adc_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, tw;
    logic pready, pslverr, adcValid, adcReady, outValid, outReady;
    logic outChan, er, done, hold = 1'b0;
    logic [11:0] adcDataA, adcDataB, amp = 12'h400;
    logic [15:0] outI, outQ, total = 16'h0000;
    logic [4:0] expQ[$];
    int err_count = 0;
    int compares = 0;
    int seed = 34;

    always #2.5 sys_clk = ~sys_clk;

    wddc_core #(.FIFO_DEPTH(32)) wddc_core_i (.*);
    wddc_adc_model wddc_adc_model_i (.*);

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    // Idle cycle after each transfer keeps psel from two writes per step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge sys_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        chk(n < 20, "bus hang");
    endtask

    task automatic rdx(input logic [7:0] a, input logic [31:0] e,
                       input logic ee);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd === e && er === ee, "register read");
    endtask

    function automatic logic [1:0] kind(input logic [15:0] v);
        return v === 16'h0000 ? 2'd0 : (v[15] ? 2'd2 : 2'd1);
    endfunction

    always @(posedge sys_clk) begin : mon
        logic [4:0] e;
        if (!rst && outValid === 1'b1 && outReady === 1'b1) begin
            if (expQ.size() == 0) begin
                chk(1'b0, "unexpected word");
            end else begin
                e = expQ.pop_front();
                chk({outChan, kind(outI), kind(outQ)} === e, "word");
            end
        end
    end

    task automatic run(input int m);
        logic [4:0] ex;
        int n, two, w;
        two = m / 3;
        n = two ? (4 << (m % 3)) : (8 << (m % 3));
        ex = m[0] ? 5'b0_00_10 : 5'b0_01_00;
        amp <= 12'h400 | 12'($random(seed) & 1023);
        apb(1'b1, 8'h0C, m[0] ? 32'h4000_0000 : 32'h0);
        apb(1'b1, 8'h04, 32'h0000_0000);
        apb(1'b1, 8'h08, $random(seed));
        apb(1'b1, 8'h00, {26'h0, 1'(two), 1'b0, 2'(m % 3), 1'(two), 1'b1});
        chk(er === 1'b0, "mode accepted");
        for (w = 0; w < 64 / n; w++) begin
            expQ.push_back(ex);
            if (two)
                expQ.push_back(5'b1_00_00);
        end
        // Ready is low one cycle after the restart; offer samples after it
        @(posedge sys_clk);
        total <= 16'd64;
        hold <= (m == 3);
        for (w = 0; w < 600 && !(done && expQ.size() == 0); w++) begin
            @(posedge sys_clk);
            if (m == 3 && w == 150) begin
                apb(1'b0, 8'h1C, 32'h0);
                chk(rd[13:8] >= 28 && rd[13:8] <= 32, "fifo full");
                hold <= 1'b0;
            end
        end
        chk(done && expQ.size() == 0, "run complete");
        total <= 16'h0000;
        // Only the stalled drain refuses samples, so only it flags overrun
        rdx(8'h1C, {30'h0, m == 3, 1'b1}, 1'b0);
        apb(1'b1, 8'h1C, 32'h0000_0002);
    endtask

    task automatic end_sim();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rdx(8'h00, 32'h0, 1'b0);
        rdx(8'h1C, 32'h0, 1'b0);
        rdx(8'h20, 32'h0, 1'b1);
        rdx(8'h06, 32'h0, 1'b1);
        tw = $random(seed);
        apb(1'b1, 8'h04, tw);
        rdx(8'h04, tw, 1'b0);
        apb(1'b1, 8'h10, ~tw);
        rdx(8'h10, ~tw, 1'b0);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, 8'h00, i ? 32'h0000_000F : 32'h0000_000D);
            chk(er === 1'b1, "bad decimation refused");
        end
        rdx(8'h00, 32'h0, 1'b0);
        apb(1'b1, 8'h14, 32'h0000_0020);
        for (int i = 0; i < 32; i++)
            apb(1'b1, 8'h18, 32'h0000_0000);
        apb(1'b1, 8'h14, 32'h0000_003F);
        rdx(8'h18, 32'h0, 1'b0);
        apb(1'b1, 8'h14, 32'h0000_001F);
        apb(1'b1, 8'h18, tw & 32'h0000_FFFF);
        apb(1'b1, 8'h14, 32'h0000_001F);
        rdx(8'h18, tw & 32'h0000_FFFF, 1'b0);
        for (int m = 0; m < 6; m++)
            run(m);
        end_sim();
    end

    initial begin
        #100000;
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end
endmodule // tb_top
